// file: hw/ppi_pkg.sv
// Purpose: shared constants for the polled pin pattern interrupt
// Assumes: 8-bit input port, one core clock
// Notes: none
`default_nettype none
package ppi_pkg;
	localparam int PPI_PORT_W = 8;
	localparam logic [7:0] PPI_MASK_OFF = 8'h00;
	localparam logic [7:0] PPI_ZERO = 8'h00;
endpackage
`default_nettype wire

// file: hw/ppi_pin_sync.sv
// Purpose: two-stage synchroniser for the input port
// Assumes: pins are asynchronous to core_clk
// Notes: first stage read only by the second
`timescale 1ns/1ps
`default_nettype none
module ppi_pin_sync #(
	parameter int W = 8
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= d_in;
			sync_reg <= meta_reg;
		end
	end
	assign q_out = sync_reg;
endmodule
`default_nettype wire

// file: hw/ppi_core.sv
// Purpose: polled pattern-match interrupt beside a command sequencer
// Assumes: sequencer pulses poll/arm/return strobes on core_clk
// Notes: one interrupt request pulse, sequencer performs the call
// How it works
// - Condition is polled at each check point the sequencer reports.
// - A true armed condition at a check point pulses the call request.
// - Input bits with mask zero never take part in the match.
// - One active and one pending mask and compare pair are held; an arm outside the handler replaces the active pair unless a call fires in its cycle.
// - Arming with a zero mask disables the interrupt.
// - Taking the interrupt clears the armed state.
// - An arm issued in the handler before its return cycle takes effect only at that return.
// - A re-armed still-true condition may fire right after return.
// - On the call any pending delay remainder is flushed.
// - Bit n of mask and compare matches pin n, pin 7 the MSB.
// - Masked pin levels form a byte compared with the compare byte.
// - The trigger is a level match of all selected pins at once.
`timescale 1ns/1ps
`default_nettype none
module ppi_core
	import ppi_pkg::*;
#(
	parameter int PORT_W = PPI_PORT_W
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [PORT_W-1:0] port_pins,
	input wire logic poll_point,
	input wire logic in_delay,
	input wire logic arm_strobe,
	input wire logic [PORT_W-1:0] arm_compare,
	input wire logic [PORT_W-1:0] arm_mask,
	input wire logic handler_return,
	output logic call_req,
	output logic delay_flush,
	output logic in_handler,
	output logic armed,
	output logic [PORT_W-1:0] cur_mask,
	output logic [PORT_W-1:0] cur_compare
);
	// Match logic and operands are byte wide only
	if (PORT_W != PPI_PORT_W) begin : g_width_chk
		$error("ppi_core supports an 8-bit port only");
	end

	logic [PORT_W-1:0] pins_s;
	logic [PORT_W-1:0] mask_reg;
	logic [PORT_W-1:0] cmp_reg;
	logic armed_reg;
	logic [PORT_W-1:0] pmask_reg;
	logic [PORT_W-1:0] pcmp_reg;
	logic pend_reg;
	logic hand_reg;
	logic call_reg;
	logic flush_reg;
	logic hit;
	logic fire;

	ppi_pin_sync #(.W(PORT_W)) u_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.d_in(port_pins),
		.q_out(pins_s)
	);

	function automatic logic pat_match(input logic [PORT_W-1:0] p,
		input logic [PORT_W-1:0] m, input logic [PORT_W-1:0] c);
		// No special case for compare bits outside the mask
		return (p & m) == c;
	endfunction

	assign hit = pat_match(pins_s, mask_reg, cmp_reg);
	// Polls during a delay are reported every cycle by the sequencer
	assign fire = poll_point && armed_reg && hit && !hand_reg;

	// Active pattern; arms outside the handler load at once unless a call fires that cycle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_reg <= PPI_MASK_OFF;
			cmp_reg <= PPI_ZERO;
			armed_reg <= 1'b0;
		end else if (fire) begin
			armed_reg <= 1'b0;
		end else if (arm_strobe && !hand_reg) begin
			mask_reg <= arm_mask;
			cmp_reg <= arm_compare;
			armed_reg <= (arm_mask != PPI_MASK_OFF);
		end else if (handler_return && hand_reg && pend_reg) begin
			mask_reg <= pmask_reg;
			cmp_reg <= pcmp_reg;
			armed_reg <= (pmask_reg != PPI_MASK_OFF);
		end
	end

	// Arms inside the handler wait here until the first return after their cycle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pmask_reg <= PPI_ZERO;
			pcmp_reg <= PPI_ZERO;
			pend_reg <= 1'b0;
		end else if (arm_strobe && hand_reg) begin
			pmask_reg <= arm_mask;
			pcmp_reg <= arm_compare;
			pend_reg <= 1'b1;
		end else if (handler_return && hand_reg) begin
			pend_reg <= 1'b0;
		end
	end

	// Handler occupancy; the program's return ends it
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			hand_reg <= 1'b0;
		else if (fire)
			hand_reg <= 1'b1;
		else if (handler_return)
			hand_reg <= 1'b0;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			call_reg <= 1'b0;
			flush_reg <= 1'b0;
		end else begin
			call_reg <= fire;
			flush_reg <= fire && in_delay;
		end
	end

	assign call_req = call_reg;
	assign delay_flush = flush_reg;
	assign in_handler = hand_reg;
	assign armed = armed_reg;
	assign cur_mask = mask_reg;
	assign cur_compare = cmp_reg;

	property p_fire_call;
		@(posedge core_clk) disable iff (!rst_n)
		(poll_point && armed && !in_handler
			&& ((pins_s & cur_mask) == cur_compare))
		|=> call_req && in_handler && !armed;
	endproperty
	a_fire_call: assert property (p_fire_call)
		else $error("match did not call handler");

	property p_no_false_call;
		@(posedge core_clk) disable iff (!rst_n)
		call_req |-> $past(armed) && $past(poll_point)
			&& (($past(pins_s) & $past(cur_mask)) == $past(cur_compare));
	endproperty
	a_no_false_call: assert property (p_no_false_call)
		else $error("call without a match");

	property p_disarm;
		@(posedge core_clk) disable iff (!rst_n)
		call_req |-> !armed;
	endproperty
	a_disarm: assert property (p_disarm)
		else $error("still armed after call");

	property p_defer;
		@(posedge core_clk) disable iff (!rst_n)
		(in_handler && arm_strobe && !handler_return) |=> !armed;
	endproperty
	a_defer: assert property (p_defer)
		else $error("handler arm took effect early");

	property p_zero_mask;
		@(posedge core_clk) disable iff (!rst_n)
		(arm_strobe && !in_handler && !fire && arm_mask == PPI_MASK_OFF)
		|=> !armed;
	endproperty
	a_zero_mask: assert property (p_zero_mask)
		else $error("zero mask left interrupt armed");

	property p_replace;
		@(posedge core_clk) disable iff (!rst_n)
		(arm_strobe && !in_handler && !fire)
		|=> cur_mask == $past(arm_mask) && cur_compare == $past(arm_compare);
	endproperty
	a_replace: assert property (p_replace)
		else $error("arm did not replace pattern");

	property p_flush;
		@(posedge core_clk) disable iff (!rst_n)
		delay_flush |-> call_req && $past(in_delay);
	endproperty
	a_flush: assert property (p_flush)
		else $error("flush without call in delay");

	property p_rearm_return;
		@(posedge core_clk) disable iff (!rst_n)
		(in_handler && arm_strobe && arm_mask != PPI_MASK_OFF)
		##1 (handler_return && !arm_strobe)[*1] |=> armed;
	endproperty
	a_rearm_return: assert property (p_rearm_return)
		else $error("rearm not active after return");

	property p_poll_only;
		@(posedge core_clk) disable iff (!rst_n)
		!poll_point |=> !call_req;
	endproperty
	a_poll_only: assert property (p_poll_only)
		else $error("call outside a check point");

	property p_quiet_handler;
		@(posedge core_clk) disable iff (!rst_n)
		in_handler |=> !call_req;
	endproperty
	a_quiet_handler: assert property (p_quiet_handler)
		else $error("call while handler still running");

	property p_hold_in_handler;
		@(posedge core_clk) disable iff (!rst_n)
		(in_handler && !handler_return) |=> !armed;
	endproperty
	a_hold_in_handler: assert property (p_hold_in_handler)
		else $error("armed before handler return");

	property p_flush_only_delay;
		@(posedge core_clk) disable iff (!rst_n)
		call_req |-> delay_flush == $past(in_delay);
	endproperty
	a_flush_only_delay: assert property (p_flush_only_delay)
		else $error("flush does not follow delay state");
endmodule
`default_nettype wire

// file: sim/ppi_seq_model.sv
// Purpose: sequencer stand-in that runs the handler and returns
// Assumes: call_req is a one-cycle pulse
// Notes: handler length fixed by HLEN
`timescale 1ns/1ps
`default_nettype none
module ppi_seq_model #(
	parameter int HLEN = 4
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic call_req,
	output logic handler_return
);
	logic [3:0] cnt_reg;
	// Every handler ends in a return
	assign handler_return = (cnt_reg == 4'h1);
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 4'h0;
		end else if (call_req) begin
			cnt_reg <= HLEN[3:0];
		end else if (cnt_reg != 4'h0) begin
			cnt_reg <= cnt_reg - 4'h1;
		end
	end
endmodule
`default_nettype wire

// file: sim/polled_pin_pattern_interrupt_tb.sv
// Purpose: self-checking bench for the pattern interrupt
// Assumes: handler model returns a few cycles after each call
// Notes: pin sync delay absorbed by bounded waits
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin \
	bad_count++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module polled_pin_pattern_interrupt_tb;
	logic core_clk, rst_n, poll_point, in_delay, arm_strobe, handler_return;
	logic call_req, delay_flush, in_handler, armed;
	logic [7:0] port_pins, arm_compare, arm_mask, cur_mask, cur_compare;
	int bad_count = 0;
	int num_checks = 0;
	ppi_core dut_u (.core_clk(core_clk), .rst_n(rst_n),
		.port_pins(port_pins), .poll_point(poll_point), .in_delay(in_delay),
		.arm_strobe(arm_strobe), .arm_compare(arm_compare),
		.arm_mask(arm_mask), .handler_return(handler_return),
		.call_req(call_req), .delay_flush(delay_flush),
		.in_handler(in_handler), .armed(armed), .cur_mask(cur_mask),
		.cur_compare(cur_compare));
	ppi_seq_model mdl_u (.core_clk(core_clk), .rst_n(rst_n),
		.call_req(call_req), .handler_return(handler_return));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic step();
		@(posedge core_clk);
		#1;
	endtask
	task automatic arm(input logic [7:0] c, input logic [7:0] m);
		step();
		arm_strobe = 1'b1;
		arm_compare = c;
		arm_mask = m;
		step();
		arm_strobe = 1'b0;
	endtask
	// Bounded wait; a missing call ends the run
	task automatic expect_call(input logic e, input logic fl);
		logic got;
		got = 1'b0;
		for (int i = 0; i < 8 && !got; i++) begin
			step();
			got = (call_req === 1'b1);
		end
		`CHK("call", e, got)
		if (e && !got) end_sim();
		if (got) begin
			`CHK("flush", fl, delay_flush)
			`CHK("armed", 1'b0, armed)
			`CHK("in_handler", 1'b1, in_handler)
		end
	endtask
	task automatic t_fire();
		port_pins = 8'hfb;
		in_delay = 1'b1;
		arm(8'h80, 8'h84);
		`CHK("cur_compare", 8'h80, cur_compare)
		`CHK("cur_mask", 8'h84, cur_mask)
		expect_call(1'b0, 1'b0);
		poll_point = 1'b1;
		expect_call(1'b1, 1'b1);
		expect_call(1'b0, 1'b0);
		`CHK("in_handler", 1'b0, in_handler)
	endtask
	task automatic t_nomatch();
		in_delay = 1'b0;
		port_pins = 8'h84;
		arm(8'h80, 8'h84);
		expect_call(1'b0, 1'b0);
		port_pins = 8'h04;
		expect_call(1'b0, 1'b0);
		port_pins = 8'hff;
		arm(8'h01, 8'h80);
		expect_call(1'b0, 1'b0);
		// Hold off polls so the first pattern cannot fire early
		poll_point = 1'b0;
		port_pins = 8'h80;
		arm(8'h80, 8'h84);
		arm(8'h04, 8'h84);
		`CHK("cur_compare", 8'h04, cur_compare)
		poll_point = 1'b1;
		expect_call(1'b0, 1'b0);
		// Zero compare would match anything if still armed
		arm(8'h00, 8'h00);
		`CHK("armed", 1'b0, armed)
		expect_call(1'b0, 1'b0);
	endtask
	task automatic t_rearm();
		arm(8'h80, 8'h84);
		expect_call(1'b1, 1'b0);
		arm(8'h80, 8'h84);
		`CHK("armed", 1'b0, armed)
		expect_call(1'b1, 1'b0);
	endtask
	initial begin
		{rst_n, poll_point, in_delay, arm_strobe} = 4'h0;
		{port_pins, arm_compare, arm_mask} = 24'h0;
		repeat (2) @(posedge core_clk);
		#1;
		rst_n = 1'b1;
		`CHK("armed", 1'b0, armed)
		t_fire();
		t_nomatch();
		t_rearm();
		end_sim();
	end
endmodule
`default_nettype wire
